// *** hw/rpls_regs.svh ***
// register offsets, field positions, reset values and timing counts
// assumes a 125 MHz core clock and byte-wide registers behind i2c
`ifndef RPLS_REGS_SVH
`define RPLS_REGS_SVH
// number of receive ports
`define RPLS_NUM_PORTS       2
// register offsets
`define RPLS_ADDR_PORT_SEL   8'h4c
`define RPLS_ADDR_STS1       8'h4d
`define RPLS_ADDR_STS2       8'h4e
`define RPLS_ADDR_FREQ_HI    8'h4f
`define RPLS_ADDR_FREQ_LO    8'h50
`define RPLS_RESET_BYTE      8'h00
// port select fields
`define RPLS_SEL_PHYS        6
`define RPLS_SEL_RD          4
`define RPLS_SEL_WR1         1
`define RPLS_SEL_WR0         0
// first status register fields
`define RPLS_STS1_RPORT      6
`define RPLS_STS1_CRC        5
`define RPLS_STS1_LCHG       4
`define RPLS_STS1_SEQ        3
`define RPLS_STS1_PAR        2
`define RPLS_STS1_PASS       1
`define RPLS_STS1_LOCK       0
`define RPLS_STS1_RC_MASK    8'h38
// second status register fields
`define RPLS_STS2_LVAR       7
`define RPLS_STS2_LCHG       6
`define RPLS_STS2_ENC        5
`define RPLS_STS2_BUF        4
`define RPLS_STS2_CSI        3
`define RPLS_STS2_STABLE     2
`define RPLS_STS2_CABLE      1
`define RPLS_STS2_CCHG       0
`define RPLS_STS2_RC_MASK    8'hf1
// link event and level positions
`define RPLS_EV_CRC          0
`define RPLS_EV_SEQ          1
`define RPLS_EV_LVAR         2
`define RPLS_EV_LCHG         3
`define RPLS_EV_ENC          4
`define RPLS_EV_BUF          5
`define RPLS_EV_CCHG         6
`define RPLS_EV_PAR          7
`define RPLS_LV_LOCK         0
`define RPLS_LV_PASS         1
`define RPLS_LV_CSI          2
// timing
`define RPLS_MCLK_MHZ        125
`define RPLS_FREQ_WIN_US     256
`define RPLS_FREQ_WIN_CYC    (`RPLS_FREQ_WIN_US * `RPLS_MCLK_MHZ)
`define RPLS_CABLE_TO_NS     1000
`define RPLS_CABLE_TO_CYC    ((`RPLS_CABLE_TO_NS * `RPLS_MCLK_MHZ) / 1000)
// device address on i2c, arbitrary value
`define RPLS_I2C_ADDR        7'h30
`endif

// *** hw/rpls_pkg.sv ***
// types for the receive port status bank
// assumes nothing beyond the constants header
package rpls_pkg;
	// =====================================================
	// i2c slave states
	typedef enum logic [3:0]
	{
		RPLS_IDLE, RPLS_DEVADR, RPLS_DEVACK, RPLS_PTR, RPLS_PTRACK,
		RPLS_WDAT, RPLS_WACK, RPLS_RDAT, RPLS_RACK
	} rpls_i2c_e;
	// =====================================================
	// link side state
	typedef struct packed {
		logic [1:0]  rs_sync; // reset synchroniser
		logic [7:0]  ev_tog;  // one toggle per event
		logic [2:0]  lvl;     // live levels
		logic [15:0] cnt;     // free running link cycle count
		logic [15:0] gray;    // gray copy of the count
	} rpls_link_s;
	// =====================================================
	// core side state
	typedef struct packed {
		logic [1:0]       scl_s;   // scl synchroniser
		logic [1:0]       sda_s;   // sda synchroniser
		logic             scl_d;   // previous scl
		logic             sda_d;   // previous sda
		rpls_i2c_e        st;      // slave state
		logic [2:0]       bitn;    // bit counter
		logic [7:0]       sh;      // shift register
		logic             rw;      // read transfer
		logic [7:0]       ptr;     // register pointer
		logic [7:0]       rd_snap; // byte being read
		logic [7:0]       rd_addr; // its offset
		logic             sda_oe;  // pulls sda low
		logic             sda_out; // driven level
		logic [2:0]       sel;     // read port, write enables
		logic [1:0][7:0]  ev_s1;   // event toggle sync, first
		logic [1:0][7:0]  ev_s2;   // event toggle sync, second
		logic [1:0][7:0]  ev_d;    // event toggle, previous
		logic [1:0][2:0]  lv_s1;   // level sync, first
		logic [1:0][2:0]  lv_s2;   // level sync, second
		logic [1:0]       lock_d;  // previous lock level
		logic [1:0][15:0] g_s1;    // gray count sync, first
		logic [1:0][15:0] g_s2;    // gray count sync, second
		logic [1:0][7:0]  sts1f;   // sticky flags, first status
		logic [1:0][7:0]  sts2f;   // sticky flags, second status
		logic [1:0][15:0] par_cnt; // parity error count
		logic [1:0]       par_over;// count above limit
		logic [15:0]      win;     // measurement window
		logic [1:0][15:0] cnt_prev;// count at last window end
		logic [1:0][15:0] freq;    // measured rate, 1/256 mhz
		logic [1:0]       stable;  // rate settled
		logic [1:0][15:0] last_g;  // last seen gray count
		logic [1:0][11:0] idle;    // cycles without link clock
		logic [1:0]       cable;   // cable fault
	} rpls_core_s;
endpackage

// *** hw/rpls_if.sv ***
// carrier from the link side of one port to the core side
// assumes every signal is a flop on the link clock
`timescale 1ns/1ps
`default_nettype none
interface rpls_if;
	logic [7:0]  ev_tog;  // event toggles
	logic [2:0]  lvl;     // live levels
	logic [15:0] gray;    // gray coded cycle count
	// link end drives, core end samples
	modport link (output ev_tog, lvl, gray);
	modport core (input ev_tog, lvl, gray);
endinterface
`default_nettype wire

// *** hw/rpls_port.sv ***
// link side of one receive port: events to toggles, cycle count in gray
// assumes event pulses and levels are synchronous to link_clk
`timescale 1ns/1ps
`default_nettype none
`include "rpls_regs.svh"
module rpls_port (
	// clock and reset
	input  wire logic        link_clk,
	input  wire logic        srst,         // core domain, resynced here
	// receiver events, one link cycle each
	input  wire logic [7:0]  event_pulse,
	// receiver levels
	input  wire logic        receiver_locked,
	input  wire logic        pass_met,
	input  wire logic [3:0]  fault_detail,
	// to the core side
	rpls_if.link             up
);
	// =====================================================
	// state
	rpls_pkg::rpls_link_s s_reg;  // registered state
	rpls_pkg::rpls_link_s s_next; // next state

	// =====================================================
	// next state
	always_comb
	begin
		s_next = s_reg;
		// reset arrives from the core clock, two flops deep
		s_next.rs_sync = {s_reg.rs_sync[0], srst};
		if (s_reg.rs_sync[1])
		begin
			s_next.ev_tog = 8'h00;
			s_next.lvl    = 3'h0;
			s_next.cnt    = 16'h0000;
			s_next.gray   = 16'h0000;
		end
		else
		begin
			// a toggle per event survives the crossing
			s_next.ev_tog = s_reg.ev_tog ^ event_pulse;
			// csi summary is any detail bit set
			s_next.lvl = {|fault_detail, pass_met, receiver_locked};
			s_next.cnt  = s_reg.cnt + 16'h0001;
			s_next.gray = s_reg.cnt ^ (s_reg.cnt >> 1);
		end
	end

	// =====================================================
	// registers
	always_ff @(posedge link_clk)
		s_reg <= s_next;

	// outputs to the carrier
	assign up.ev_tog = s_reg.ev_tog;
	assign up.lvl    = s_reg.lvl;
	assign up.gray   = s_reg.gray;
endmodule // rpls_port
`default_nettype wire

// *** hw/rpls_top.sv ***
// receive port status bank of a dual port link hub, reached over i2c
// assumes open drain sda resolved outside, one link clock per port
// Notes on behaviour
// - port select steers each per-port access
// - first status bit 6 shows read port
// - checksum fault sets bit 5, read clears
// - lock change sets bit 4, read clears
// - order fault sets bit 3, read clears
// - bit 2 high while parity count exceeds limit
// - clearing parity counters drops bit 2
// - bit 1 shows live pass criteria
// - bit 0 shows live receiver lock
// - unequal row lengths set bit 7 until read
// - row length change sets bit 6, read clears
// - encoding fault sets bit 5, read clears
// - buffer overflow sets bit 4, read clears
// - bit 3 summarises camera receive faults
// - bit 1 flags missing link clock when expected
// - row count change sets bit 0, read clears
// - high byte gives integer megahertz
// - low byte gives 1/256 megahertz fraction
// - read port field picks port block
`timescale 1ns/1ps
`default_nettype none
`include "rpls_regs.svh"
module rpls_top #(
	parameter int FREQ_WIN_CYC = `RPLS_FREQ_WIN_CYC // window length
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             srst,
	// i2c pins
	input  wire logic             scl_in,
	input  wire logic             sda_in,
	output logic                  sda_out,
	output logic                  sda_oe,
	// link clocks, one per port
	input  wire logic [1:0]       rx_link_clk,
	// receiver event pulses, link clock domain
	input  wire logic [1:0]       control_channel_checksum_fault,
	input  wire logic [1:0]       control_channel_order_fault,
	input  wire logic [1:0]       row_length_varies_flag,
	input  wire logic [1:0]       row_length_changed_flag,
	input  wire logic [1:0]       link_encoding_fault,
	input  wire logic [1:0]       buffer_overflow,
	input  wire logic [1:0]       row_count_changed_flag,
	input  wire logic [1:0]       parity_error,
	// receiver levels, link clock domain
	input  wire logic [1:0]       receiver_locked_flag,
	input  wire logic [1:0]       pass_met,
	input  wire logic [1:0][3:0]  camera_rx_fault_detail,
	// core domain controls
	input  wire logic [1:0][15:0] parity_limit_setting,
	input  wire logic [1:0]       parity_count_clear,
	input  wire logic [1:0]       link_expected
);
	// =====================================================
	// state and crossing wires
	rpls_pkg::rpls_core_s s_reg;  // registered state
	rpls_pkg::rpls_core_s s_next; // next state
	logic [1:0][7:0]  ev_tog_w;   // event toggles from link side
	logic [1:0][2:0]  lvl_w;      // levels from link side
	logic [1:0][15:0] gray_w;     // gray counts from link side

	// =====================================================
	// read decode, used on every byte load
	function automatic logic [7:0] rpls_rd(
		input logic [7:0]          a,
		input rpls_pkg::rpls_core_s s
	);
		logic       rp;
		logic [7:0] d;
		rp = s.sel[2];
		d  = `RPLS_RESET_BYTE;
		case (a)
			`RPLS_ADDR_PORT_SEL:
			begin
				// physical port reads 0 over local i2c
				d[`RPLS_SEL_RD]  = s.sel[2];
				d[`RPLS_SEL_WR1] = s.sel[1];
				d[`RPLS_SEL_WR0] = s.sel[0];
			end
			`RPLS_ADDR_STS1:
			begin
				d = s.sts1f[rp] & `RPLS_STS1_RC_MASK;
				d[`RPLS_STS1_RPORT] = rp;
				d[`RPLS_STS1_PAR]   = s.par_over[rp];
				d[`RPLS_STS1_PASS]  = s.lv_s2[rp][`RPLS_LV_PASS];
				d[`RPLS_STS1_LOCK]  = s.lv_s2[rp][`RPLS_LV_LOCK];
			end
			`RPLS_ADDR_STS2:
			begin
				d = s.sts2f[rp] & `RPLS_STS2_RC_MASK;
				d[`RPLS_STS2_CSI]    = s.lv_s2[rp][`RPLS_LV_CSI];
				d[`RPLS_STS2_STABLE] = s.stable[rp];
				d[`RPLS_STS2_CABLE]  = s.cable[rp];
			end
			`RPLS_ADDR_FREQ_HI:
				d = s.freq[rp][15:8];
			`RPLS_ADDR_FREQ_LO:
				d = s.freq[rp][7:0];
			default:
				d = `RPLS_RESET_BYTE;
		endcase
		return d;
	endfunction

	// gray to binary for the rate count
	function automatic logic [15:0] rpls_g2b(input logic [15:0] g);
		logic [15:0] b;
		b = g;
		for (int i = 14; i >= 0; i--)
			b[i] = b[i+1] ^ g[i];
		return b;
	endfunction

	// =====================================================
	// link side of each port
	genvar g;
	generate
		for (g = 0; g < `RPLS_NUM_PORTS; g++)
		begin : g_port
			rpls_if u_if ();
			// event order matches the event positions
			rpls_port u_port (
				.link_clk        (rx_link_clk[g]),
				.srst            (srst),
				.event_pulse     ({parity_error[g],
				                   row_count_changed_flag[g],
				                   buffer_overflow[g],
				                   link_encoding_fault[g],
				                   row_length_changed_flag[g],
				                   row_length_varies_flag[g],
				                   control_channel_order_fault[g],
				                   control_channel_checksum_fault[g]}),
				.receiver_locked (receiver_locked_flag[g]),
				.pass_met        (pass_met[g]),
				.fault_detail    (camera_rx_fault_detail[g]),
				.up              (u_if.link)
			);
			assign ev_tog_w[g] = u_if.ev_tog;
			assign lvl_w[g]    = u_if.lvl;
			assign gray_w[g]   = u_if.gray;
		end
	endgenerate

	// =====================================================
	// next state: i2c slave, flags, rate and cable watch
	always_comb
	begin
		logic        scl;
		logic        sda;
		logic        rise;
		logic        fall;
		logic        start;
		logic        stop;
		logic        rp;
		logic [7:0]  wd;
		logic [7:0]  evp;
		logic [15:0] bin;
		logic [15:0] f;
		logic [15:0] dif;
		logic [15:0] pc;
		scl   = s_reg.scl_s[1];
		sda   = s_reg.sda_s[1];
		rise  = scl & ~s_reg.scl_d;
		fall  = ~scl & s_reg.scl_d;
		start = scl & s_reg.scl_d & s_reg.sda_d & ~sda;
		stop  = scl & s_reg.scl_d & ~s_reg.sda_d & sda;
		rp    = s_reg.sel[2];
		wd    = {s_reg.sh[6:0], sda};
		evp   = 8'h00;
		bin   = 16'h0000;
		f     = 16'h0000;
		dif   = 16'h0000;
		pc    = 16'h0000;
		s_next = s_reg;
		// pin synchronisers and edge history
		s_next.scl_s = {s_reg.scl_s[0], scl_in};
		s_next.sda_s = {s_reg.sda_s[0], sda_in};
		s_next.scl_d = scl;
		s_next.sda_d = sda;
		s_next.sda_out = 1'b0;

		// i2c slave, start and stop take precedence
		if (start)
		begin
			s_next.st     = rpls_pkg::RPLS_DEVADR;
			s_next.bitn   = 3'h0;
			s_next.sda_oe = 1'b0;
		end
		else if (stop)
		begin
			s_next.st     = rpls_pkg::RPLS_IDLE;
			s_next.sda_oe = 1'b0;
		end
		else
		begin
			case (s_reg.st)
				rpls_pkg::RPLS_DEVADR, rpls_pkg::RPLS_PTR,
				rpls_pkg::RPLS_WDAT:
					// shift in on rising scl
					if (rise)
					begin
						s_next.sh   = wd;
						s_next.bitn = s_reg.bitn + 3'h1;
						if (s_reg.bitn == 3'h7)
						begin
							if (s_reg.st == rpls_pkg::RPLS_DEVADR)
							begin
								s_next.rw = sda;
								s_next.st = (s_reg.sh[6:0] == `RPLS_I2C_ADDR) ?
									rpls_pkg::RPLS_DEVACK :
									rpls_pkg::RPLS_IDLE;
							end
							else if (s_reg.st == rpls_pkg::RPLS_PTR)
							begin
								s_next.ptr = wd;
								s_next.st  = rpls_pkg::RPLS_PTRACK;
							end
							else
							begin
								// status bytes are read only, writes
								// reach only the port select
								if (s_reg.ptr == `RPLS_ADDR_PORT_SEL)
									s_next.sel = {wd[`RPLS_SEL_RD],
										wd[`RPLS_SEL_WR1],
										wd[`RPLS_SEL_WR0]};
								s_next.st = rpls_pkg::RPLS_WACK;
							end
						end
					end
				rpls_pkg::RPLS_DEVACK, rpls_pkg::RPLS_PTRACK,
				rpls_pkg::RPLS_WACK:
					// first fall pulls ack, second releases it
					if (fall)
					begin
						s_next.sda_oe = ~s_reg.sda_oe;
						s_next.bitn   = 3'h0;
						if (s_reg.sda_oe)
						begin
							if (s_reg.st == rpls_pkg::RPLS_WACK)
								s_next.ptr = s_reg.ptr + 8'h01;
							if (s_reg.st == rpls_pkg::RPLS_DEVACK && s_reg.rw)
							begin
								// load the first read byte
								s_next.rd_addr = s_reg.ptr;
								s_next.rd_snap = rpls_rd(s_reg.ptr, s_reg);
								s_next.sh      = rpls_rd(s_reg.ptr, s_reg);
								s_next.sda_oe  = ~s_next.rd_snap[7];
								s_next.st      = rpls_pkg::RPLS_RDAT;
							end
							else if (s_reg.st == rpls_pkg::RPLS_DEVACK)
								s_next.st = rpls_pkg::RPLS_PTR;
							else
								s_next.st = rpls_pkg::RPLS_WDAT;
						end
					end
				rpls_pkg::RPLS_RDAT:
				begin
					// master samples on rise, next bit on fall
					if (rise)
					begin
						s_next.bitn = s_reg.bitn + 3'h1;
						if (s_reg.bitn == 3'h7)
						begin
							s_next.st   = rpls_pkg::RPLS_RACK;
							s_next.bitn = 3'h0;
						end
					end
					if (fall && s_reg.bitn != 3'h0)
					begin
						s_next.sh     = {s_reg.sh[6:0], 1'b0};
						s_next.sda_oe = ~s_reg.sh[6];
					end
				end
				rpls_pkg::RPLS_RACK:
				begin
					if (fall && s_reg.bitn == 3'h0)
						s_next.sda_oe = 1'b0; // master acks now
					if (rise)
					begin
						// byte complete: clear the bits it carried
						s_next.bitn = 3'h1;
						s_next.rw   = ~sda; // ack asks for more
						s_next.ptr  = s_reg.ptr + 8'h01;
						if (s_reg.rd_addr == `RPLS_ADDR_STS1)
							s_next.sts1f[rp] = s_reg.sts1f[rp] &
								~(s_reg.rd_snap & `RPLS_STS1_RC_MASK);
						if (s_reg.rd_addr == `RPLS_ADDR_STS2)
							s_next.sts2f[rp] = s_reg.sts2f[rp] &
								~(s_reg.rd_snap & `RPLS_STS2_RC_MASK);
					end
					if (fall && s_reg.bitn != 3'h0)
					begin
						if (s_reg.rw)
						begin
							s_next.rd_addr = s_reg.ptr;
							s_next.rd_snap = rpls_rd(s_reg.ptr, s_reg);
							s_next.sh      = rpls_rd(s_reg.ptr, s_reg);
							s_next.sda_oe  = ~s_next.rd_snap[7];
							s_next.bitn    = 3'h0;
							s_next.st      = rpls_pkg::RPLS_RDAT;
						end
						else
							s_next.st = rpls_pkg::RPLS_IDLE;
					end
				end
				rpls_pkg::RPLS_IDLE:
					s_next.sda_oe = 1'b0;
				default:
				begin
					s_next.st     = rpls_pkg::RPLS_IDLE;
					s_next.sda_oe = 1'b0;
				end
			endcase
		end

		// measurement window shared by both ports
		s_next.win = (s_reg.win == 16'(FREQ_WIN_CYC - 1)) ?
			16'h0000 : s_reg.win + 16'h0001;

		// per port crossing, flags, parity, rate, cable
		for (int p = 0; p < `RPLS_NUM_PORTS; p++)
		begin
			s_next.ev_s1[p] = ev_tog_w[p];
			s_next.ev_s2[p] = s_reg.ev_s1[p];
			s_next.ev_d[p]  = s_reg.ev_s2[p];
			s_next.lv_s1[p] = lvl_w[p];
			s_next.lv_s2[p] = s_reg.lv_s1[p];
			s_next.g_s1[p]  = gray_w[p];
			s_next.g_s2[p]  = s_reg.g_s1[p];
			s_next.lock_d[p] = s_reg.lv_s2[p][`RPLS_LV_LOCK];
			evp = s_reg.ev_s2[p] ^ s_reg.ev_d[p];
			// events set after any clear, so the set wins
			s_next.sts1f[p][`RPLS_STS1_CRC] = s_next.sts1f[p][`RPLS_STS1_CRC]
				| evp[`RPLS_EV_CRC];
			s_next.sts1f[p][`RPLS_STS1_LCHG] = s_next.sts1f[p][`RPLS_STS1_LCHG]
				| (s_reg.lv_s2[p][`RPLS_LV_LOCK] ^ s_reg.lock_d[p]);
			s_next.sts1f[p][`RPLS_STS1_SEQ] = s_next.sts1f[p][`RPLS_STS1_SEQ]
				| evp[`RPLS_EV_SEQ];
			s_next.sts2f[p][`RPLS_STS2_LVAR] = s_next.sts2f[p][`RPLS_STS2_LVAR]
				| evp[`RPLS_EV_LVAR];
			s_next.sts2f[p][`RPLS_STS2_LCHG] = s_next.sts2f[p][`RPLS_STS2_LCHG]
				| evp[`RPLS_EV_LCHG];
			// encoding faults set the flag whatever the lock level
			s_next.sts2f[p][`RPLS_STS2_ENC] = s_next.sts2f[p][`RPLS_STS2_ENC]
				| evp[`RPLS_EV_ENC];
			s_next.sts2f[p][`RPLS_STS2_BUF] = s_next.sts2f[p][`RPLS_STS2_BUF]
				| evp[`RPLS_EV_BUF];
			s_next.sts2f[p][`RPLS_STS2_CCHG] = s_next.sts2f[p][`RPLS_STS2_CCHG]
				| evp[`RPLS_EV_CCHG];

			// parity count saturates, clearing it drops the flag
			pc = s_reg.par_cnt[p];
			if (parity_count_clear[p])
				pc = 16'h0000;
			else if (evp[`RPLS_EV_PAR] && pc != 16'hffff)
				pc = pc + 16'h0001;
			s_next.par_cnt[p]  = pc;
			s_next.par_over[p] = (pc > parity_limit_setting[p]);

			// no gray movement for the timeout means no link clock
			if (s_reg.g_s2[p] != s_reg.last_g[p])
			begin
				s_next.last_g[p] = s_reg.g_s2[p];
				s_next.idle[p]   = 12'h000;
				s_next.cable[p]  = 1'b0;
			end
			else if (s_reg.idle[p] == 12'(`RPLS_CABLE_TO_CYC - 1))
				s_next.cable[p] = link_expected[p];
			else
				s_next.idle[p] = s_reg.idle[p] + 12'h001;
			if (!link_expected[p])
				s_next.cable[p] = 1'b0;

			// link cycles per window give 1/256 mhz units
			if (s_reg.win == 16'(FREQ_WIN_CYC - 1))
			begin
				bin = rpls_g2b(s_reg.g_s2[p]);
				f   = s_reg.cable[p] ? 16'h0000 : bin - s_reg.cnt_prev[p];
				dif = f - s_reg.freq[p];
				s_next.cnt_prev[p] = bin;
				s_next.freq[p]     = f;
				s_next.stable[p]   = ~s_reg.cable[p] & (f != 16'h0000) &
					(dif == 16'h0000 || dif == 16'h0001 ||
					 dif == 16'hffff);
			end
			if (s_reg.cable[p])
				s_next.stable[p] = 1'b0;
		end
	end

	// =====================================================
	// registers
	always_ff @(posedge mclk)
	begin
		if (srst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	// outputs straight from flops
	assign sda_oe  = s_reg.sda_oe;
	assign sda_out = s_reg.sda_out;
endmodule // rpls_top
`default_nettype wire

// *** verification/rpls_link_model.sv ***
// remote serializer model: one link-cycle pulse per request toggle
// assumes the bench toggles each request bit at most once per 40 mclk
`timescale 1ns/1ps
`default_nettype none
module rpls_link_model (
	// link clock
	input  wire logic       link_clk,
	// requests from the bench
	input  wire logic [7:0] req,
	input  wire logic [5:0] lv_req,
	// receiver side outputs
	output var  logic [7:0] ev,
	output var  logic [5:0] lv
);
	logic [7:0] seen = 8'h00; // last request seen
	// a changed request bit gives a single pulse; levels follow
	always @(posedge link_clk)
	begin
		ev <= req ^ seen;
		seen <= req;
		lv <= lv_req;
	end
endmodule // rpls_link_model
`default_nettype wire

// *** verification/rpls_top_monitor.sv ***
// pin checks of the i2c side of the status bank
// assumes binding to rpls_top; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module rpls_top_monitor (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// i2c pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe
);
	// ==========================================================
	// cycles since scl was last seen high
	logic [3:0] low_cnt;
	always_ff @(posedge mclk)
		low_cnt <= scl_in ? 4'h0 : low_cnt + {3'h0, low_cnt != 4'hf};
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// start: sda falls while scl stays high
	sequence s_start;
		scl_in && $past(scl_in) && $fell(sda_in);
	endsequence
	AST_NO_DRIVE_HIGH: assert property (sda_out == 1'b0)
		else $error("sda driven high");
	AST_RESET_QUIET: assert property (disable iff (1'b0)
		srst |=> !sda_oe) else $error("sda pulled in reset");
	AST_START_QUIET: assert property (s_start |=> !sda_oe [*8])
		else $error("sda pulled during address");
	AST_OE_HOLD: assert property ($rose(sda_oe) |-> sda_oe [*8])
		else $error("pulled bit too short");
	AST_SCL_HIGH_STABLE: assert property
		(scl_in && $past(scl_in) |-> $stable(sda_oe)) else $error("sda moved");
	AST_RISE_LATE: assert property
		($rose(sda_oe) |-> !$past(scl_in, 2))
		else $error("pull too soon after scl fall");
	AST_CHANGE_WINDOW: assert property
		($changed(sda_oe) |-> low_cnt inside {[2:7]}) else $error("late sda");
	AST_RELEASE_LOW: assert property ($fell(sda_oe) |-> !scl_in)
		else $error("release with scl high");
endmodule // rpls_top_monitor
bind rpls_top rpls_top_monitor u_mon (.mclk(mclk), .srst(srst),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// *** verification/tb.sv ***
// bench for the status bank: i2c master, link models, flag model
// assumes hw/ design files, the link model and the pin monitor
`timescale 1ns/1ps
`default_nettype none
`include "rpls_regs.svh"
module tb;
	// ==========================================================
	// stimulus and expected flags
	localparam int CNT = 2114; // link cycles per short window
	logic mclk = 1'b0, srst = 1'b1, scl = 1'b1, sda_m = 1'b1;
	logic sda_oe, rp = 1'b0, lrun = 1'b1;
	logic [1:0] lclk = 2'h0, pclr = 2'h0, lexp = 2'h3;
	logic [1:0][7:0] rq = 16'h0000, s1 = 16'h0000, s2 = 16'h0000;
	logic [1:0][5:0] lq = 12'h000;
	logic [1:0][15:0] plim = 32'h0002ffff;
	wire [1:0][7:0] e;
	wire [1:0][5:0] lv;
	wire sda_in = sda_m & ~sda_oe; // pulled-up line
	int pc [2] = '{0, 0};
	int errors = 0, compares = 0, seed = 32'h10cdc204;
	always #4 mclk = ~mclk;
	initial #3 forever #16 lclk[0] = ~lclk[0];
	initial #11 forever #16 lclk[1] = lrun ? ~lclk[1] : lclk[1];
	rpls_link_model u_m0 (.link_clk(lclk[0]), .req(rq[0]),
		.lv_req(lq[0]), .ev(e[0]), .lv(lv[0]));
	rpls_link_model u_m1 (.link_clk(lclk[1]), .req(rq[1]),
		.lv_req(lq[1]), .ev(e[1]), .lv(lv[1]));
	rpls_top #(.FREQ_WIN_CYC(CNT * 4)) u_dut (.mclk(mclk), .srst(srst),
		.scl_in(scl), .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe),
		.rx_link_clk(lclk), .parity_error({e[1][7], e[0][7]}),
		.control_channel_checksum_fault({e[1][0], e[0][0]}),
		.control_channel_order_fault({e[1][1], e[0][1]}),
		.row_length_varies_flag({e[1][2], e[0][2]}),
		.row_length_changed_flag({e[1][3], e[0][3]}),
		.link_encoding_fault({e[1][4], e[0][4]}),
		.buffer_overflow({e[1][5], e[0][5]}),
		.row_count_changed_flag({e[1][6], e[0][6]}),
		.receiver_locked_flag({lv[1][0], lv[0][0]}),
		.pass_met({lv[1][1], lv[0][1]}), .link_expected(lexp),
		.camera_rx_fault_detail({lv[1][5:2], lv[0][5:2]}),
		.parity_limit_setting(plim), .parity_count_clear(pclr));
	task automatic tk(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one i2c bit: data moves while scl low, sampled while high
	task automatic ib(input logic b, output logic r);
		scl = 1'b0;
		tk(2);
		sda_m = b;
		tk(6);
		scl = 1'b1;
		tk(4);
		r = sda_in;
		tk(4);
	endtask
	// start is (1,0), stop is (0,1)
	task automatic cond(input logic a, input logic b);
		logic x;
		ib(a, x);
		sda_m = b;
		tk(8);
	endtask
	task automatic xb(input logic [7:0] d, output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--)
			ib(d[i], q[i]);
		ib(1'b1, a);
	endtask
	// register write when w, else pointer set and one byte read
	task automatic io(input logic w, input logic [7:0] a, d,
		output logic [7:0] q);
		logic [7:0] x;
		cond(1'b1, 1'b0);
		xb({`RPLS_I2C_ADDR, 1'b0}, x);
		xb(a, x);
		if (w)
			xb(d, x);
		else
		begin
			cond(1'b1, 1'b0);
			xb({`RPLS_I2C_ADDR, 1'b1}, x);
			xb(8'hff, q);
		end
		cond(1'b0, 1'b1);
	endtask
	// events m and levels v on port p, model updated alongside
	task automatic stim(input int p, input logic [7:0] m,
		input logic [5:0] v);
		s1[p] |= {2'h0, m[0], v[0] != lq[p][0], m[1], 3'h0};
		// host counting taken as enabled, so encoding faults show
		s2[p] |= {m[2], m[3], m[4], m[5], 3'h0, m[6]};
		pc[p] += int'(m[7]);
		rq[p] ^= m;
		lq[p] = v;
		tk(40);
	endtask
	// both status bytes of port p; a read clears the sticky bits
	task automatic cs(input int p);
		logic [7:0] q, x;
		io(1'b0, 8'h4d, 8'h00, q);
		x = {1'b0, rp, 3'h0, pc[p] > int'(plim[p]), lq[p][1:0]};
		chk(q & 8'h38, s1[p]);
		chk(q & 8'hc7, x);
		s1[p] = 8'h00;
		io(1'b0, 8'h4e, 8'h00, q);
		x = {4'h0, |lq[p][5:2], 3'h4};
		chk(q & 8'hf1, s2[p]);
		chk(q & 8'h0e, x);
		s2[p] = 8'h00;
	endtask
	task automatic final_report;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial
	begin
		logic [31:0] r;
		logic [7:0] q;
		tk(16);
		srst = 1'b0;
		// settled needs two agreeing windows after the short first one
		tk(CNT * 12 + 800);
		for (int k = 0; k < 4; k++)
		begin
			r = $random(seed);
			stim(0, (r[7:0] | (8'h7f >> (2 * k))) & 8'h7f, r[13:8]);
			cs(0);
		end
		cs(0);
		io(1'b1, 8'h4c, 8'h10, q);
		rp = 1'b1;
		io(1'b0, 8'h4c, 8'h00, q);
		chk(q, 8'h10);
		stim(1, 8'h80, 6'h00);
		stim(1, 8'h80, 6'h00);
		cs(1);
		stim(1, 8'h80, 6'h00);
		io(1'b1, 8'h4d, 8'hff, q);
		cs(1);
		pclr[1] = 1'b1;
		tk(1);
		pclr[1] = 1'b0;
		pc[1] = 0;
		cs(1);
		io(1'b0, 8'h4f, 8'h00, q);
		chk(q, 8'(CNT / 256));
		io(1'b0, 8'h50, 8'h00, q);
		chk(q, 8'(CNT % 256));
		io(1'b0, 8'h60, 8'h00, q);
		chk(q, 8'h00);
		lrun = 1'b0;
		tk(300);
		io(1'b0, 8'h4e, 8'h00, q);
		chk(q & 8'h0a, 8'h02);
		// no fault is reported while the link is not expected
		lexp[1] = 1'b0;
		tk(4);
		io(1'b0, 8'h4e, 8'h00, q);
		chk(q & 8'h02, 8'h00);
		final_report;
	end
	initial
	begin
		tk(80000);
		errors++;
		final_report;
	end
endmodule // tb
`default_nettype wire
